// *** design/ggch_pkg.sv ***
package ggch_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 5;

  // Interface message bytes, compared with the parity bit stripped.
  localparam logic [7:0] CMD_MASK = 8'h7f;
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam int GRP_LSB = 5;
  localparam int RQS_BIT = 6;

  localparam int CLOCK_PERIOD_NS = 50;
  localparam int IFC_MIN_NS = 100000;
  localparam int IFC_CYCLES = (IFC_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int IFC_CNT_W = $clog2(IFC_CYCLES + 1);

  // Pin inputs passing the synchroniser: dio, atn, ifc, ren, dav, local key.
  localparam int SYNC_W = BYTE_W + 5;

  typedef enum logic {GGCH_POLL_OFF, GGCH_POLL_ON} ggch_poll_t;

  typedef struct packed {
    logic mux;
    logic [3:0] func;
    logic [3:0] range;
    logic [3:0] fmt;
    logic [3:0] eoi;
    logic [3:0] srq;
    logic dfilt;
    logic [3:0] filt;
    logic [3:0] zero;
    logic [3:0] interval;
    logic [3:0] size;
    logic [3:0] rate;
    logic [3:0] trig;
    logic [3:0] delay;
    logic [3:0] term;
  } ggch_cfg_t;

  localparam int CFG_W = $bits(ggch_cfg_t);

  localparam logic TRIG_GET_ONESHOT_UNUSED = 1'b0;
  localparam logic [3:0] TRIG_GET_ONESHOT = 4'h2;
  localparam logic [3:0] TRIG_GET_CONT = 4'h3;

  localparam ggch_cfg_t FACTORY_CFG = '{
    mux: 1'b1,
    func: 4'h0,
    range: 4'h4,
    fmt: 4'h0,
    eoi: 4'h0,
    srq: 4'h0,
    dfilt: 1'b1,
    filt: 4'h0,
    zero: 4'h0,
    interval: 4'h0,
    size: 4'h1,
    rate: 4'h3,
    trig: 4'h6,
    delay: 4'h0,
    term: 4'h0
  };
endpackage : ggch_pkg

// *** design/ggch_sync.sv ***
`timescale 1ns/10ps
module ggch_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Asynchronous inputs and their settled copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } ggch_sync_t;

  ggch_sync_t st;
  ggch_sync_t next_st;

  // A bit only moves once the second and third stages agree.
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stable_out = st.q;
endmodule : ggch_sync

// *** design/ggch_command_handler.sv ***
// What this block does
// - Interface clear drops talker and listener states and their indicators.
// - Local lockout also disables the return-to-local key.
// - Lockout holds until remote enable goes false.
// - Addressed go-to-local leaves remote and re-enables the front panel.
// - Go-to-local never cancels an active local lockout.
// - Device clear acts unaddressed, loading factory or user-saved defaults.
// - Factory defaults: mux on, DC volts, 300V, prefix, filters, CR LF.
// - Factory defaults: continuous external trigger, 6.5 digit rate, one-shot store.
// - Factory defaults enable EOI and bus hold-off on execute.
// - Both clears restore the default line frequency.
// - Neither clear changes the bus address.
// - Selective clear only when addressed to listen, same effect as clear.
// - Trigger command starts a measurement only in an accepting trigger mode.
// - In serial poll, the addressed talker drives its status byte with ATN off.
// - Poll disable ends serial poll mode and stops the status byte.
// - Poll mode persists, so each talk addressing returns the status byte.
// - The status byte shows whether the device is requesting service.
// - Remote is entered only by listen addressing while remote enable is true.
// - Remote locks all keys but local and lights the remote indicator.
`timescale 1ns/10ps
module ggch_command_handler (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bus management and handshake lines
  input wire logic atn,
  input wire logic ifc,
  input wire logic ren,
  input wire logic dav,
  // Data lines
  input wire logic [ggch_pkg::BYTE_W-1:0] dio,
  output logic [ggch_pkg::BYTE_W-1:0] dio_out,
  output logic dio_oe,
  // Service request line
  input wire logic srq,
  output logic srq_out,
  output logic srq_oe,
  // Front panel
  input wire logic local_key,
  output logic talk_active_indicator,
  output logic listen_active_indicator,
  output logic remote_mode_indicator,
  output logic front_panel_enable,
  output logic local_key_enable,
  output logic local_lockout,
  // Address and status
  input wire logic [ggch_pkg::ADDR_W-1:0] bus_address,
  input wire logic [ggch_pkg::BYTE_W-1:0] status_byte,
  input wire logic service_request,
  // Configuration
  input wire logic use_saved_defaults,
  input wire logic [ggch_pkg::CFG_W-1:0] saved_cfg,
  input wire logic [ggch_pkg::CFG_W-1:0] parsed_cfg,
  input wire logic parsed_cfg_load,
  input wire logic line_freq_default,
  input wire logic line_freq_in,
  output logic [ggch_pkg::CFG_W-1:0] config_out,
  output logic line_freq,
  // Events to the measurement side
  output logic defaults_loaded,
  output logic factory_loaded,
  output logic measure_start,
  output logic data_strobe,
  output logic [ggch_pkg::BYTE_W-1:0] data_byte
);
  typedef struct packed {
    logic dav_q;
    logic local_q;
    logic [ggch_pkg::IFC_CNT_W-1:0] ifc_cnt;
    logic talk;
    logic listen;
    logic remote;
    logic lockout;
    logic panel_en;
    logic local_en;
    ggch_pkg::ggch_poll_t poll;
    logic [ggch_pkg::CFG_W-1:0] cfg;
    logic line_freq;
    logic clear_pulse;
    logic factory_pulse;
    logic measure;
    logic data_pulse;
    logic [ggch_pkg::BYTE_W-1:0] data;
    logic [ggch_pkg::BYTE_W-1:0] dio_out;
    logic dio_oe;
    logic srq_on;
  } ggch_state_t;

  localparam logic [ggch_pkg::IFC_CNT_W-1:0] IFC_LAST =
    ggch_pkg::IFC_CNT_W'(ggch_pkg::IFC_CYCLES - 1);

  localparam ggch_state_t ST_RESET = '{
    poll: ggch_pkg::GGCH_POLL_OFF,
    cfg: ggch_pkg::FACTORY_CFG,
    panel_en: 1'b1,
    local_en: 1'b1,
    default: '0
  };

  ggch_state_t st;
  ggch_state_t next_st;
  logic [ggch_pkg::SYNC_W-1:0] sync_q;
  logic [ggch_pkg::BYTE_W-1:0] s_dio;
  logic s_atn;
  logic s_ifc;
  logic s_ren;
  logic s_dav;
  logic s_local;
  logic [ggch_pkg::BYTE_W-1:0] cmd_b;
  logic take;
  logic cmd;
  logic ifc_accept;
  logic is_mla;
  logic is_mta;
  logic is_talk_grp;
  logic do_gtl;
  logic do_llo;
  logic do_clear;
  logic do_get;
  logic mla_cmd;
  logic local_press;
  ggch_pkg::ggch_cfg_t cur_cfg;

  ggch_sync #(
    .WIDTH(ggch_pkg::SYNC_W)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({local_key, dav, ren, ifc, atn, dio}),
    .stable_out(sync_q)
  );

  assign {s_local, s_dav, s_ren, s_ifc, s_atn, s_dio} = sync_q;
  assign cmd_b = s_dio & ggch_pkg::CMD_MASK;
  assign cur_cfg = ggch_pkg::ggch_cfg_t'(st.cfg);
  assign take = s_dav && !st.dav_q;
  assign cmd = take && s_atn;
  assign ifc_accept = s_ifc && (st.ifc_cnt == IFC_LAST);
  assign is_mla = cmd_b == {1'b0, ggch_pkg::GRP_LISTEN, bus_address};
  assign is_mta = cmd_b == {1'b0, ggch_pkg::GRP_TALK, bus_address};
  assign is_talk_grp = cmd_b[ggch_pkg::GRP_LSB +: 2] == ggch_pkg::GRP_TALK;
  assign mla_cmd = cmd && is_mla;
  assign do_gtl = cmd && st.listen && (cmd_b == ggch_pkg::CMD_GTL);
  assign do_llo = cmd && (cmd_b == ggch_pkg::CMD_LLO);
  // Device clear needs no addressing; selective clear needs listen addressing.
  assign do_clear = cmd && ((cmd_b == ggch_pkg::CMD_DCL) ||
    (st.listen && (cmd_b == ggch_pkg::CMD_SDC)));
  assign do_get = cmd && st.listen && (cmd_b == ggch_pkg::CMD_GET) &&
    ((cur_cfg.trig == ggch_pkg::TRIG_GET_ONESHOT) ||
     (cur_cfg.trig == ggch_pkg::TRIG_GET_CONT));
  assign local_press = s_local && !st.local_q;

  always_comb begin
    next_st = st;
    next_st.dav_q = s_dav;
    next_st.local_q = s_local;
    next_st.clear_pulse = 1'b0;
    next_st.factory_pulse = 1'b0;
    next_st.measure = 1'b0;
    next_st.data_pulse = 1'b0;

    if (!s_ifc) begin
      next_st.ifc_cnt = '0;
    end else if (st.ifc_cnt != IFC_LAST) begin
      next_st.ifc_cnt = st.ifc_cnt + 1'b1;
    end

    if (ifc_accept) begin
      next_st.talk = 1'b0;
      next_st.listen = 1'b0;
    end else if (cmd) begin
      if (is_mla) begin
        next_st.listen = 1'b1;
        next_st.talk = 1'b0;
      end else if (is_mta) begin
        next_st.talk = 1'b1;
        next_st.listen = 1'b0;
      end else if (is_talk_grp) begin
        next_st.talk = 1'b0;
      end else if (cmd_b == ggch_pkg::CMD_UNL) begin
        next_st.listen = 1'b0;
      end
    end

    if (!s_ren) begin
      next_st.remote = 1'b0;
      next_st.lockout = 1'b0;
    end else begin
      if (mla_cmd) begin
        next_st.remote = 1'b1;
      end else if (do_gtl) begin
        next_st.remote = 1'b0;
      end else if (local_press && !st.lockout) begin
        next_st.remote = 1'b0;
      end
      if (do_llo) begin
        next_st.lockout = 1'b1;
      end
    end
    next_st.panel_en = !next_st.remote;
    next_st.local_en = !next_st.lockout;

    // The bus address is a port, so no clear can ever alter it.
    if (do_clear) begin
      next_st.clear_pulse = 1'b1;
      next_st.factory_pulse = !use_saved_defaults;
      next_st.cfg = use_saved_defaults ? saved_cfg : ggch_pkg::FACTORY_CFG;
      next_st.line_freq = line_freq_default;
    end else if (parsed_cfg_load) begin
      next_st.cfg = parsed_cfg;
      next_st.line_freq = line_freq_in;
    end

    next_st.measure = do_get;

    if (cmd && (cmd_b == ggch_pkg::CMD_SPE)) begin
      next_st.poll = ggch_pkg::GGCH_POLL_ON;
    end else if (cmd && (cmd_b == ggch_pkg::CMD_SPD)) begin
      next_st.poll = ggch_pkg::GGCH_POLL_OFF;
    end

    if (take && !s_atn && st.listen) begin
      next_st.data_pulse = 1'b1;
      next_st.data = s_dio;
    end

    // Poll mode survives re-addressing, so every talk addressing answers.
    next_st.dio_oe = next_st.talk && !s_atn &&
      (next_st.poll == ggch_pkg::GGCH_POLL_ON);
    next_st.dio_out = '0;
    if (next_st.dio_oe) begin
      next_st.dio_out = status_byte;
      next_st.dio_out[ggch_pkg::RQS_BIT] = service_request;
    end
    next_st.srq_on = service_request;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dio_out = st.dio_out;
  assign dio_oe = st.dio_oe;
  assign srq_out = st.srq_on;
  assign srq_oe = st.srq_on;
  assign talk_active_indicator = st.talk;
  assign listen_active_indicator = st.listen;
  assign remote_mode_indicator = st.remote;
  assign front_panel_enable = st.panel_en;
  assign local_key_enable = st.local_en;
  assign local_lockout = st.lockout;
  assign config_out = st.cfg;
  assign line_freq = st.line_freq;
  assign defaults_loaded = st.clear_pulse;
  assign factory_loaded = st.factory_pulse;
  assign measure_start = st.measure;
  assign data_strobe = st.data_pulse;
  assign data_byte = st.data;

  // Helper count of consecutive asserted IFC cycles, read only by assertions.
  logic [ggch_pkg::IFC_CNT_W-1:0] ifc_run;
  always_ff @(posedge clock) begin
    if (reset || !s_ifc) begin
      ifc_run <= '0;
    end else if (ifc_run != IFC_LAST) begin
      ifc_run <= ifc_run + 1'b1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence seq_clear_cmd;
    do_clear && !use_saved_defaults;
  endsequence

  sequence seq_pulse_once;
    defaults_loaded ##1 !defaults_loaded;
  endsequence

  sequence seq_spd;
    cmd && (cmd_b == ggch_pkg::CMD_SPD);
  endsequence

  AST_IFC_IDLE: assert property (ifc_accept |=> !talk_active_indicator && !listen_active_indicator)
    else $error("talker or listener still active after interface clear");
  AST_IFC_MIN: assert property ($rose(ifc_accept) |-> ifc_run == IFC_LAST)
    else $error("interface clear accepted before its minimum time");
  AST_LLO_KEY: assert property (do_llo && s_ren |=> !local_key_enable && local_lockout)
    else $error("local key still enabled after lockout");
  AST_LOCK_HOLD: assert property (local_lockout && s_ren |=> local_lockout)
    else $error("lockout dropped while remote enable true");
  AST_LOCK_DROP: assert property (!s_ren |=> !local_lockout && !remote_mode_indicator)
    else $error("lockout or remote kept after remote enable false");
  AST_GTL: assert property (do_gtl && !mla_cmd |=> !remote_mode_indicator && front_panel_enable)
    else $error("go to local did not restore local mode");
  AST_CLEAR: assert property (seq_clear_cmd |=> seq_pulse_once)
    else $error("clear did not produce a single defaults pulse");
  AST_FACTORY: assert property (factory_loaded |-> config_out == ggch_pkg::FACTORY_CFG)
    else $error("factory defaults not loaded");
  AST_LINE_FREQ: assert property (do_clear |=> line_freq == $past(line_freq_default))
    else $error("line frequency not restored by clear");
  AST_SDC_ADDR: assert property (cmd && !st.listen && cmd_b == ggch_pkg::CMD_SDC |=> !defaults_loaded)
    else $error("selective clear acted while not addressed");
  AST_GET_MODE: assert property (measure_start |->
    $past(cur_cfg.trig == ggch_pkg::TRIG_GET_ONESHOT
    || cur_cfg.trig == ggch_pkg::TRIG_GET_CONT) && $past(st.listen))
    else $error("measurement started in a trigger mode that refuses it");
  AST_POLL_END: assert property (seq_spd |=> !dio_oe [*2])
    else $error("status byte still driven after poll disable");
  AST_POLL_DRIVE: assert property (dio_oe |-> talk_active_indicator &&
    !$past(s_atn) && dio_out[ggch_pkg::RQS_BIT] == $past(service_request))
    else $error("status byte driven wrongly");
  AST_REMOTE_IN: assert property ($rose(remote_mode_indicator) |-> $past(mla_cmd && s_ren))
    else $error("remote entered without listen addressing under remote enable");
  AST_PANEL: assert property (front_panel_enable == !remote_mode_indicator)
    else $error("front panel enable does not follow remote mode");
  AST_DATA: assert property (data_strobe |-> $past(!s_atn && st.listen))
    else $error("data byte taken under ATN");
endmodule : ggch_command_handler

// *** tb/ggch_host_model.sv ***
`timescale 1ns/10ps
module ggch_host_model (
  // Clock
  input wire logic clock,
  // Device drive of the data lines
  input wire logic dio_oe,
  input wire logic [7:0] dio_out,
  // Bus lines driven by the controller
  output logic atn,
  output logic ifc,
  output logic ren,
  output logic dav,
  output logic [7:0] dio
);
  logic [7:0] hdio;

  // Released lines carry the inverse of the last byte, so a stale copy never passes.
  assign dio = dio_oe ? dio_out : hdio;

  initial begin
    atn = 1'b0;
    ifc = 1'b0;
    ren = 1'b0;
    dav = 1'b0;
    hdio = 8'h00;
  end

  task automatic put(input logic a, input logic [7:0] b);
    @(posedge clock);
    atn <= a;
    // The byte goes out only once the device has seen ATN and let go of the data lines.
    repeat (6) @(posedge clock);
    hdio <= b;
    repeat (4) @(posedge clock);
    dav <= 1'b1;
    repeat (5) @(posedge clock);
    dav <= 1'b0;
    repeat (4) @(posedge clock);
    hdio <= ~b;
    repeat (4) @(posedge clock);
  endtask : put

  task automatic set_atn(input logic v);
    @(posedge clock);
    atn <= v;
    repeat (6) @(posedge clock);
  endtask : set_atn

  task automatic set_ren(input logic v);
    @(posedge clock);
    ren <= v;
    repeat (6) @(posedge clock);
  endtask : set_ren

  task automatic hold_ifc(input int n);
    @(posedge clock);
    ifc <= 1'b1;
    repeat (n) @(posedge clock);
    ifc <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : hold_ifc
endmodule : ggch_host_model

// *** tb/tb_ggch_command_handler.sv ***
`timescale 1ns/10ps
module tb_ggch_command_handler;
  localparam logic [7:0] OWN_LISTEN_ADDRESS = 8'h27;
  localparam logic [7:0] OWN_TALK_ADDRESS = 8'h47;
  logic clock, reset, atn, ifc, ren, dav, dio_oe, srq_out, srq_oe, local_key;
  logic talk, listen, remote, fpe, lke, lockout, line_freq, dl, fl, ms, ds;
  logic service_request, use_saved, load, lf_in, lf_def;
  logic [4:0] addr;
  logic [7:0] dio, dio_out, status_byte, data_byte;
  ggch_pkg::ggch_cfg_t pc, sc, co;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_dl = 0;
  int n_fl = 0;
  int n_ms = 0;
  int n_ds = 0;

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ggch_host_model host (.clock(clock), .dio_oe(dio_oe), .dio_out(dio_out), .atn(atn),
    .ifc(ifc), .ren(ren), .dav(dav), .dio(dio));

  ggch_command_handler dut (
    .clock(clock), .reset(reset), .atn(atn), .ifc(ifc), .ren(ren), .dav(dav), .dio(dio),
    .dio_out(dio_out), .dio_oe(dio_oe), .srq(srq_oe), .srq_out(srq_out), .srq_oe(srq_oe),
    .local_key(local_key), .talk_active_indicator(talk), .listen_active_indicator(listen),
    .remote_mode_indicator(remote), .front_panel_enable(fpe), .local_key_enable(lke),
    .local_lockout(lockout), .bus_address(addr), .status_byte(status_byte),
    .service_request(service_request), .use_saved_defaults(use_saved), .saved_cfg(sc),
    .parsed_cfg(pc), .parsed_cfg_load(load), .line_freq_default(lf_def),
    .line_freq_in(lf_in), .config_out(co), .line_freq(line_freq), .defaults_loaded(dl),
    .factory_loaded(fl), .measure_start(ms), .data_strobe(ds), .data_byte(data_byte));

  // Event pulses last one cycle, so they are tallied here and compared as counts.
  always @(posedge clock) begin
    n_dl <= n_dl + int'(dl === 1'b1);
    n_fl <= n_fl + int'(fl === 1'b1);
    n_ms <= n_ms + int'(ms === 1'b1);
    n_ds <= n_ds + int'(ds === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic press_key();
    @(posedge clock);
    local_key <= 1'b1;
    repeat (6) @(posedge clock);
    local_key <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : press_key

  task automatic load_cfg(input logic [3:0] trig);
    @(posedge clock);
    pc.trig <= trig;
    load <= 1'b1;
    lf_in <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : load_cfg

  initial begin
    reset = 1'b1;
    local_key = 1'b0;
    status_byte = 8'h85;
    service_request = 1'b1;
    use_saved = 1'b0;
    load = 1'b0;
    lf_in = 1'b0;
    lf_def = 1'b0;
    addr = 5'h07;
    pc = ggch_pkg::FACTORY_CFG;
    pc.func = 4'h2;
    sc = ggch_pkg::FACTORY_CFG;
    sc.trig = 4'h2;
    sc.range = 4'h1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    check(co, ggch_pkg::FACTORY_CFG);
    check({talk, listen, remote, lockout, fpe, lke, dio_oe}, 7'h06);
    host.set_ren(1'b1);
    host.put(1'b0, OWN_LISTEN_ADDRESS);
    check({remote, listen}, 2'b00);
    host.put(1'b1, OWN_LISTEN_ADDRESS);
    check({remote, listen, fpe}, 3'b110);
    host.put(1'b0, ggch_pkg::CMD_DCL);
    check({n_ds, n_dl}, {32'd1, 32'd0});
    check(data_byte, 8'h14);
    load_cfg(4'h3);
    check({co, line_freq}, {pc, 1'b1});
    host.put(1'b1, ggch_pkg::CMD_UNL);
    host.put(1'b1, ggch_pkg::CMD_SDC);
    check(co, pc);
    host.put(1'b1, ggch_pkg::CMD_DCL);
    check({co, line_freq}, {ggch_pkg::FACTORY_CFG, 1'b0});
    check(n_fl, 1);
    host.put(1'b1, OWN_LISTEN_ADDRESS);
    check(listen, 1'b1);
    load_cfg(4'h3);
    use_saved <= 1'b1;
    host.put(1'b1, ggch_pkg::CMD_SDC);
    check({co, line_freq}, {sc, 1'b0});
    check({n_dl, n_fl}, {32'd2, 32'd1});
    host.put(1'b1, ggch_pkg::CMD_GET);
    check(n_ms, 1);
    load_cfg(4'h3);
    host.put(1'b1, ggch_pkg::CMD_GET);
    check(n_ms, 2);
    use_saved <= 1'b0;
    lf_def <= 1'b1;
    host.put(1'b1, ggch_pkg::CMD_DCL);
    check(line_freq, 1'b1);
    host.put(1'b1, ggch_pkg::CMD_GET);
    check(n_ms, 2);
    host.put(1'b1, ggch_pkg::CMD_LLO);
    check({lockout, lke, remote}, 3'b101);
    press_key();
    check(remote, 1'b1);
    host.put(1'b1, ggch_pkg::CMD_GTL);
    check({remote, lockout}, 2'b01);
    host.put(1'b1, OWN_LISTEN_ADDRESS);
    host.set_ren(1'b0);
    check({remote, lockout, lke, fpe}, 4'h3);
    host.set_ren(1'b1);
    host.put(1'b1, OWN_LISTEN_ADDRESS);
    host.put(1'b1, ggch_pkg::CMD_GTL);
    check({remote, fpe, lockout}, 3'b010);
    host.put(1'b1, OWN_LISTEN_ADDRESS);
    press_key();
    check({remote, fpe}, 2'b01);
    host.put(1'b1, ggch_pkg::CMD_SPE);
    host.put(1'b1, OWN_TALK_ADDRESS);
    check({talk, listen}, 2'b10);
    host.set_atn(1'b0);
    check({dio_oe, dio, srq_out, srq_oe}, {1'b1, 8'hc5, 2'b11});
    service_request <= 1'b0;
    status_byte <= 8'h52;
    repeat (4) @(posedge clock);
    check({dio, srq_out, srq_oe}, {8'h12, 2'b00});
    host.put(1'b1, 8'h5f);
    check({talk, dio_oe}, 2'b00);
    host.put(1'b1, OWN_TALK_ADDRESS);
    host.set_atn(1'b0);
    check({dio_oe, dio}, {1'b1, 8'h12});
    host.put(1'b1, ggch_pkg::CMD_SPD);
    host.set_atn(1'b0);
    check({dio_oe, talk}, 2'b01);
    host.hold_ifc(1900);
    check(talk, 1'b1);
    host.hold_ifc(2010);
    check({talk, listen}, 2'b00);
    addr <= 5'h03;
    host.put(1'b1, 8'h23);
    check({listen, remote}, 2'b11);
    print_verdict();
  end
endmodule : tb_ggch_command_handler
